//--- rtl/cti_pkg.sv
package cti_pkg;
  // ----------------------------------------------------------------
  // command unit encodings
  // ----------------------------------------------------------------
  localparam logic [7:0] CTI_CLA = 8'hA0;
  localparam logic [7:0] CTI_INS_TAG_CFG = 8'hC8;
  localparam logic [7:0] CTI_INS_TAG_DL = 8'hCA;
  localparam logic [7:0] CTI_INS_STORE_ID = 8'hDE;
  localparam logic [7:0] CTI_P_ZERO = 8'h00;
  localparam logic [7:0] CTI_P1_SERIAL = 8'h00;
  localparam logic [7:0] CTI_P1_EQUIP = 8'h01;
  localparam logic [7:0] CTI_LC_TAG_CFG = 8'h04;
  localparam logic [7:0] CTI_LE_TAG_DL = 8'h05;
  localparam logic [7:0] CTI_LC_STORE_ID = 8'h08;
  localparam logic [7:0] CTI_LE_STORE_ID = 8'h01;
  localparam logic [7:0] CTI_CFG_OVERHEAD = 8'h03;
  localparam logic [7:0] CTI_DL_OVERHEAD = 8'h02;
  localparam logic [7:0] CTI_SW1_OK = 8'h90;
  // block selectors using offset/size in configuration request
  localparam logic [7:0] CTI_CFG_BLK_A = 8'h02;
  localparam logic [7:0] CTI_CFG_BLK_B = 8'h04;
  localparam logic [7:0] CTI_CFG_BLK_C = 8'h06;
  // block selectors with meaningful segment fields in download response
  localparam logic [7:0] CTI_DL_BLK_A = 8'h01;
  localparam logic [7:0] CTI_DL_BLK_B = 8'h02;
  localparam logic [7:0] CTI_DL_BLK_C = 8'h03;
  // store response bit positions
  localparam int CTI_RSP_CHANGE_BIT = 0;
  localparam int CTI_RSP_USAGE_BIT = 4;
  localparam int CTI_RSP_SHORT_BIT = 5;
  // ----------------------------------------------------------------
  // register map (word offsets, byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTI_REG_CTRL = 8'h00;
  localparam logic [7:0] CTI_REG_ARG = 8'h04;
  localparam logic [7:0] CTI_REG_ID_LO = 8'h08;
  localparam logic [7:0] CTI_REG_ID_HI = 8'h0C;
  localparam logic [7:0] CTI_REG_STATUS = 8'h10;
  localparam logic [7:0] CTI_REG_RESP = 8'h14;
  localparam logic [7:0] CTI_REG_DATA = 8'h18;
  localparam logic [31:0] CTI_RESET_WORD = 32'h0000_0000;
  localparam int CTI_BUF_DEPTH = 16;
  // command kinds written into CTRL[1:0]
  typedef enum logic [1:0] {
    CTI_CMD_TAG_CFG = 2'd0,
    CTI_CMD_TAG_DL = 2'd1,
    CTI_CMD_STORE = 2'd2
  } cti_cmd_t;
endpackage : cti_pkg

//--- rtl/cti_byte_if.sv
`timescale 1ns/1ps
// byte stream between the sequencer and the parallel card link
interface cti_byte_if;
  logic tx_valid;
  logic [7:0] tx_byte;
  logic tx_ready;
  logic rx_valid;
  logic [7:0] rx_byte;
  modport seq (output tx_valid, output tx_byte, input tx_ready, input rx_valid, input rx_byte);
  modport link (input tx_valid, input tx_byte, output tx_ready, output rx_valid, output rx_byte);
endinterface : cti_byte_if

//--- rtl/cti_link.sv
`timescale 1ns/1ps
// byte port toward the card: parallel handshake, inputs synchronised
module cti_link
  import cti_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  cti_byte_if.link bif,
  output logic card_tx_valid,
  output logic [7:0] card_tx_byte,
  input wire logic card_tx_ack,
  input wire logic card_rx_valid,
  input wire logic [7:0] card_rx_byte
);
  logic ack_s1_reg;
  logic ack_s2_reg;
  logic ack_d_reg;
  logic rv_s1_reg;
  logic rv_s2_reg;
  logic rv_d_reg;
  logic [7:0] rb_s1_reg;
  logic [7:0] rb_s2_reg;
  logic busy_reg;

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  // data byte is two stages deep like its strobe, so it is stable when read
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
      ack_d_reg <= 1'b0;
      rv_s1_reg <= 1'b0;
      rv_s2_reg <= 1'b0;
      rv_d_reg <= 1'b0;
      rb_s1_reg <= 8'h00;
      rb_s2_reg <= 8'h00;
    end else begin
      ack_s1_reg <= card_tx_ack;
      ack_s2_reg <= ack_s1_reg;
      ack_d_reg <= ack_s2_reg;
      rv_s1_reg <= card_rx_valid;
      rv_s2_reg <= rv_s1_reg;
      rv_d_reg <= rv_s2_reg;
      rb_s1_reg <= card_rx_byte;
      rb_s2_reg <= rb_s1_reg;
    end
  end

  // four-phase send: raise valid, wait for ack high, drop, wait ack low
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      card_tx_valid <= 1'b0;
      card_tx_byte <= 8'h00;
      busy_reg <= 1'b0;
    end else if (!busy_reg && bif.tx_valid && !ack_s2_reg) begin
      card_tx_valid <= 1'b1;
      card_tx_byte <= bif.tx_byte;
      busy_reg <= 1'b1;
    end else if (busy_reg && card_tx_valid && ack_s2_reg) begin
      card_tx_valid <= 1'b0;
    end else if (busy_reg && !card_tx_valid && !ack_s2_reg) begin
      busy_reg <= 1'b0;
    end
  end

  assign bif.tx_ready = !busy_reg && !ack_s2_reg;
  // one pulse per rising edge of the card's byte strobe
  assign bif.rx_valid = rv_s2_reg && !rv_d_reg;
  assign bif.rx_byte = rb_s2_reg;
endmodule : cti_link

//--- rtl/cti_host.sv
// Local design decisions: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
// Behaviour
// - configuration request: A0 C8 00 00, four body bytes, variable reply
// - download request: A0 CA 00 00, variable length, five reply bytes
// - download body: selector, block length, data; length is data plus two
// - each command unit is sent as one transport command unit
// - store-identifier: A0 DE, P2 zero, eight body bytes, one reply byte
// - P1 is 01 only with equipment id and storage service active
// - serial form: length byte then seven id bytes, least significant first
// - id length in low nibble of first body byte, upper nibble reserved
// - store-identifier is issued during initialisation; card writes id file
// - card lacking storage service gets 00 form with derived serial
// - 01 form: length byte plus seven equipment id bytes, stored in id file
// - ignore reply bit 5 when short id service is absent
module cti_host
  import cti_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hsel,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic card_tx_valid,
  output logic [7:0] card_tx_byte,
  input wire logic card_tx_ack,
  input wire logic card_rx_valid,
  input wire logic [7:0] card_rx_byte
);
  typedef enum logic [4:0] {
    CTI_ST_IDLE = 5'b00001,
    CTI_ST_HDR = 5'b00010,
    CTI_ST_BODY = 5'b00100,
    CTI_ST_RESP = 5'b01000,
    CTI_ST_SW = 5'b10000
  } cti_state_t;

  cti_byte_if bif ();
  cti_state_t state_reg;
  logic [31:0] ctrl_reg;
  logic [31:0] arg_reg;
  logic [31:0] id_lo_reg;
  logic [31:0] id_hi_reg;
  logic [7:0] buf_reg [CTI_BUF_DEPTH];
  logic [7:0] rsp_reg [CTI_BUF_DEPTH];
  logic [7:0] sw1_reg;
  logic [7:0] sw2_reg;
  logic [7:0] lc_reg;
  logic [7:0] le_reg;
  logic [7:0] cnt_reg;
  logic [3:0] rd_idx_reg;
  logic done_reg;
  logic err_reg;
  logic start_pulse;
  logic aph_valid_reg;
  logic aph_write_reg;
  logic [7:0] aph_addr_reg;
  logic [7:0] hdr_byte;
  logic [7:0] body_byte;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // offset/size only matter for three selectors; others send zeros
  function automatic logic cfg_uses_offset(input logic [7:0] sel);
    cfg_uses_offset = (sel == CTI_CFG_BLK_A) || (sel == CTI_CFG_BLK_B) || (sel == CTI_CFG_BLK_C);
  endfunction : cfg_uses_offset

  function automatic logic dl_seg_valid(input logic [7:0] sel);
    dl_seg_valid = (sel == CTI_DL_BLK_A) || (sel == CTI_DL_BLK_B) || (sel == CTI_DL_BLK_C);
  endfunction : dl_seg_valid

  cti_link u_link (
    .clk_sys(clk_sys),
    .rst(rst),
    .bif(bif),
    .card_tx_valid(card_tx_valid),
    .card_tx_byte(card_tx_byte),
    .card_tx_ack(card_tx_ack),
    .card_rx_valid(card_rx_valid),
    .card_rx_byte(card_rx_byte)
  );

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  // zero wait states; writes land at the data phase
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      aph_valid_reg <= 1'b0;
      aph_write_reg <= 1'b0;
      aph_addr_reg <= 8'h00;
    end else if (hready) begin
      aph_valid_reg <= hsel && htrans[1];
      aph_write_reg <= hwrite;
      aph_addr_reg <= haddr[7:0];
    end
  end

  assign start_pulse = aph_valid_reg && aph_write_reg && (aph_addr_reg == CTI_REG_CTRL)
                       && hwdata[31] && (state_reg == CTI_ST_IDLE);

  // software registers; writes ignored while a command runs
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_reg <= CTI_RESET_WORD;
      arg_reg <= CTI_RESET_WORD;
      id_lo_reg <= CTI_RESET_WORD;
      id_hi_reg <= CTI_RESET_WORD;
      for (int i = 0; i < CTI_BUF_DEPTH; i++) begin
        buf_reg[i] <= 8'h00;
      end
    end else if (aph_valid_reg && aph_write_reg && state_reg == CTI_ST_IDLE) begin
      case (aph_addr_reg)
        CTI_REG_CTRL: ctrl_reg <= {1'b0, hwdata[30:0]};
        CTI_REG_ARG: arg_reg <= hwdata;
        CTI_REG_ID_LO: id_lo_reg <= hwdata;
        CTI_REG_ID_HI: id_hi_reg <= hwdata;
        CTI_REG_DATA: buf_reg[hwdata[19:16]] <= hwdata[7:0];
        default: ;
      endcase
    end
  end

  // read mux registered at the address phase, ready immediately
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hrdata <= CTI_RESET_WORD;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready && hsel && htrans[1] && !hwrite) begin
        case (haddr[7:0])
          CTI_REG_CTRL: hrdata <= ctrl_reg;
          CTI_REG_ARG: hrdata <= arg_reg;
          CTI_REG_ID_LO: hrdata <= id_lo_reg;
          CTI_REG_ID_HI: hrdata <= id_hi_reg;
          CTI_REG_STATUS: hrdata <= {22'h0, err_reg, done_reg, state_reg == CTI_ST_IDLE, 7'h0};
          CTI_REG_RESP: hrdata <= {sw1_reg, sw2_reg, rsp_reg[haddr[11:8]], rsp_reg[0]};
          default: hrdata <= CTI_RESET_WORD;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // command unit composition
  // ----------------------------------------------------------------
  // header: class, ins, p1, p2, length byte
  always_comb begin
    hdr_byte = CTI_P_ZERO;
    case (cnt_reg)
      8'd0: hdr_byte = CTI_CLA;
      8'd1: begin
        case (cti_cmd_t'(ctrl_reg[1:0]))
          CTI_CMD_TAG_CFG: hdr_byte = CTI_INS_TAG_CFG;
          CTI_CMD_TAG_DL: hdr_byte = CTI_INS_TAG_DL;
          default: hdr_byte = CTI_INS_STORE_ID;
        endcase
      end
      // p1=01 only when software asserts equipment id with service active
      8'd2: hdr_byte = (ctrl_reg[1:0] == CTI_CMD_STORE && ctrl_reg[2] && ctrl_reg[3])
                       ? CTI_P1_EQUIP : CTI_P1_SERIAL;
      8'd3: hdr_byte = CTI_P_ZERO;
      default: hdr_byte = lc_reg;
    endcase
  end

  // body bytes by kind
  always_comb begin
    body_byte = 8'h00;
    case (cti_cmd_t'(ctrl_reg[1:0]))
      CTI_CMD_TAG_CFG: begin
        case (cnt_reg)
          8'd0: body_byte = arg_reg[7:0];
          8'd1: body_byte = cfg_uses_offset(arg_reg[7:0]) ? arg_reg[15:8] : 8'h00;
          8'd2: body_byte = cfg_uses_offset(arg_reg[7:0]) ? arg_reg[23:16] : 8'h00;
          default: body_byte = cfg_uses_offset(arg_reg[7:0]) ? arg_reg[31:24] : 8'h00;
        endcase
      end
      CTI_CMD_TAG_DL: begin
        case (cnt_reg)
          8'd0: body_byte = arg_reg[7:0];
          8'd1: body_byte = arg_reg[15:8];
          default: body_byte = buf_reg[4'(cnt_reg - 8'd2)];
        endcase
      end
      default: begin
        case (cnt_reg)
          8'd0: body_byte = {4'h0, id_hi_reg[27:24]};
          8'd1: body_byte = id_lo_reg[7:0];
          8'd2: body_byte = id_lo_reg[15:8];
          8'd3: body_byte = id_lo_reg[23:16];
          8'd4: body_byte = id_lo_reg[31:24];
          8'd5: body_byte = id_hi_reg[7:0];
          8'd6: body_byte = id_hi_reg[15:8];
          default: body_byte = id_hi_reg[23:16];
        endcase
      end
    endcase
  end

  assign bif.tx_valid = (state_reg == CTI_ST_HDR) || (state_reg == CTI_ST_BODY);
  assign bif.tx_byte = (state_reg == CTI_ST_HDR) ? hdr_byte : body_byte;

  // ----------------------------------------------------------------
  // transport sequencer
  // ----------------------------------------------------------------
  // one whole unit per command, status pair closes it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= CTI_ST_IDLE;
      cnt_reg <= 8'h00;
      lc_reg <= 8'h00;
      le_reg <= 8'h00;
      rd_idx_reg <= 4'h0;
      sw1_reg <= 8'h00;
      sw2_reg <= 8'h00;
      done_reg <= 1'b0;
      err_reg <= 1'b0;
      for (int i = 0; i < CTI_BUF_DEPTH; i++) begin
        rsp_reg[i] <= 8'h00;
      end
    end else begin
      case (state_reg)
        CTI_ST_IDLE: begin
          if (start_pulse) begin
            done_reg <= 1'b0;
            err_reg <= 1'b0;
            cnt_reg <= 8'h00;
            rd_idx_reg <= 4'h0;
            state_reg <= CTI_ST_HDR;
            case (cti_cmd_t'(hwdata[1:0]))
              CTI_CMD_TAG_CFG: begin
                lc_reg <= CTI_LC_TAG_CFG;
                le_reg <= hwdata[15:8] + CTI_CFG_OVERHEAD;
              end
              CTI_CMD_TAG_DL: begin
                lc_reg <= hwdata[15:8] + CTI_DL_OVERHEAD;
                le_reg <= CTI_LE_TAG_DL;
              end
              default: begin
                lc_reg <= CTI_LC_STORE_ID;
                le_reg <= CTI_LE_STORE_ID;
              end
            endcase
          end
        end
        CTI_ST_HDR: begin
          if (bif.tx_ready) begin
            cnt_reg <= (cnt_reg == 8'd4) ? 8'h00 : cnt_reg + 8'd1;
            if (cnt_reg == 8'd4) begin
              state_reg <= CTI_ST_BODY;
            end
          end
        end
        CTI_ST_BODY: begin
          if (bif.tx_ready) begin
            cnt_reg <= cnt_reg + 8'd1;
            if (cnt_reg + 8'd1 == lc_reg) begin
              cnt_reg <= 8'h00;
              state_reg <= CTI_ST_RESP;
            end
          end
        end
        CTI_ST_RESP: begin
          if (bif.rx_valid) begin
            rsp_reg[rd_idx_reg] <= bif.rx_byte;
            // ctrl bit 4 says the short id service exists; without it the select bit means nothing
            if (ctrl_reg[1:0] == CTI_CMD_STORE && !ctrl_reg[4]) begin
              rsp_reg[rd_idx_reg][CTI_RSP_SHORT_BIT] <= 1'b0;
            end
            rd_idx_reg <= rd_idx_reg + 4'd1;
            cnt_reg <= cnt_reg + 8'd1;
            if (cnt_reg + 8'd1 == le_reg) begin
              cnt_reg <= 8'h00;
              state_reg <= CTI_ST_SW;
            end
          end
        end
        CTI_ST_SW: begin
          if (bif.rx_valid) begin
            cnt_reg <= cnt_reg + 8'd1;
            if (cnt_reg == 8'd0) begin
              sw1_reg <= bif.rx_byte;
            end else begin
              sw2_reg <= bif.rx_byte;
              done_reg <= 1'b1;
              err_reg <= (sw1_reg != CTI_SW1_OK);
              state_reg <= CTI_ST_IDLE;
            end
          end
        end
        default: state_reg <= CTI_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence hdr_go_s;
    state_reg == CTI_ST_HDR && cnt_reg == 8'd0 && bif.tx_ready;
  endsequence

  cla_first_a: assert property (@(posedge clk_sys) disable iff (rst)
    hdr_go_s |-> bif.tx_byte == CTI_CLA)
    else $error("first header byte is not the class");
  p2_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
    state_reg == CTI_ST_HDR && cnt_reg == 8'd3 |-> bif.tx_byte == CTI_P_ZERO)
    else $error("second parameter byte not zero");
  store_lc_a: assert property (@(posedge clk_sys) disable iff (rst)
    state_reg == CTI_ST_HDR && ctrl_reg[1:0] == CTI_CMD_STORE |-> lc_reg == CTI_LC_STORE_ID)
    else $error("store length not eight");
  dl_le_a: assert property (@(posedge clk_sys) disable iff (rst)
    state_reg == CTI_ST_HDR && ctrl_reg[1:0] == CTI_CMD_TAG_DL |-> le_reg == CTI_LE_TAG_DL)
    else $error("download reply length not five");
  len_nibble_a: assert property (@(posedge clk_sys) disable iff (rst)
    state_reg == CTI_ST_BODY && ctrl_reg[1:0] == CTI_CMD_STORE && cnt_reg == 8'd0
    |-> bif.tx_byte[7:4] == 4'h0)
    else $error("reserved length bits set");
  cfg_ignore_a: assert property (@(posedge clk_sys) disable iff (rst)
    state_reg == CTI_ST_BODY && ctrl_reg[1:0] == CTI_CMD_TAG_CFG && cnt_reg != 8'd0
    && !cfg_uses_offset(arg_reg[7:0]) |-> bif.tx_byte == 8'h00)
    else $error("offset sent for unused selector");
  p1_form_a: assert property (@(posedge clk_sys) disable iff (rst)
    state_reg == CTI_ST_HDR && cnt_reg == 8'd2 && !ctrl_reg[3] |-> bif.tx_byte == CTI_P1_SERIAL)
    else $error("equipment form without service");
  seq_flow_a: assert property (@(posedge clk_sys) disable iff (rst)
    state_reg == CTI_ST_HDR && cnt_reg == 8'd4 && bif.tx_ready |=> state_reg == CTI_ST_BODY)
    else $error("body did not follow header");
endmodule : cti_host

//--- tb/cti_card_model.sv
`timescale 1ns/1ps
// ------------------------------
// card responder on the byte link
// ------------------------------
module cti_card_model
  import cti_pkg::*;
(
  input wire logic clk_sys,
  input wire logic card_tx_valid,
  input wire logic [7:0] card_tx_byte,
  output logic card_tx_ack,
  output logic card_rx_valid,
  output logic [7:0] card_rx_byte,
  input wire logic [3:0] lag,
  input wire logic usage_ind,
  input wire logic short_sel,
  input wire logic fail_sw
);
  logic [7:0] hdr [5];
  logic [7:0] body [16];
  logic [7:0] id_file [8];
  logic [7:0] rsp [$];
  logic [7:0] sw1;
  logic [7:0] n;
  logic use_seg;
  logic chg;

  // four-phase take: ack stays up until the strobe drops
  task automatic take(output logic [7:0] v);
    while (card_tx_valid !== 1'b1) @(posedge clk_sys);
    repeat (lag) @(posedge clk_sys);
    v = card_tx_byte;
    card_tx_ack <= 1'b1;
    @(posedge clk_sys);
    while (card_tx_valid !== 1'b0) @(posedge clk_sys);
    card_tx_ack <= 1'b0;
    @(posedge clk_sys);
  endtask : take

  // byte settles before the strobe; afterwards the line shows junk
  task automatic send(input logic [7:0] v);
    card_rx_byte <= v;
    repeat (4 + lag) @(posedge clk_sys);
    card_rx_valid <= 1'b1;
    repeat (4) @(posedge clk_sys);
    card_rx_valid <= 1'b0;
    @(posedge clk_sys);
    card_rx_byte <= ~v;
    @(posedge clk_sys);
  endtask : send

  // command loop: header, body, reply, two status bytes
  initial begin
    card_tx_ack = 1'b0;
    card_rx_valid = 1'b0;
    card_rx_byte = 8'h5A;
    foreach (id_file[i]) id_file[i] = 8'h00;
    forever begin
      foreach (hdr[i]) take(hdr[i]);
      for (int i = 0; i < hdr[4]; i++) take(body[i]);
      rsp.delete();
      sw1 = fail_sw ? 8'h6F : CTI_SW1_OK;
      if (hdr[0] !== CTI_CLA || hdr[3] !== CTI_P_ZERO) sw1 = 8'h6E;
      else if (hdr[1] === CTI_INS_TAG_CFG && hdr[2] === CTI_P_ZERO) begin
        use_seg = body[0] inside {CTI_CFG_BLK_A, CTI_CFG_BLK_B, CTI_CFG_BLK_C};
        n = use_seg ? body[3] : 8'h02;
        rsp = '{body[0], 8'h00, n};
        for (int i = 0; i < n; i++) rsp.push_back(use_seg ? body[2] + i[7:0] : 8'hEE);
      end else if (hdr[1] === CTI_INS_TAG_DL && hdr[2] === CTI_P_ZERO) begin
        use_seg = body[0] inside {CTI_DL_BLK_A, CTI_DL_BLK_B, CTI_DL_BLK_C};
        if (hdr[4] !== body[1] + CTI_DL_OVERHEAD) sw1 = 8'h67;
        rsp = '{body[0], 8'h00, use_seg ? 8'h00 : 8'hFF, use_seg ? body[1] : 8'hFF,
          use_seg ? hdr[4] - 8'h02 : 8'hFF};
      end else if (hdr[1] === CTI_INS_STORE_ID && hdr[2] <= CTI_P1_EQUIP
                   && hdr[4] === CTI_LC_STORE_ID) begin
        chg = 1'b0;
        foreach (id_file[i]) chg |= (id_file[i] !== body[i]);
        rsp = '{{2'b00, short_sel & hdr[2][0], usage_ind, 3'b000, chg}};
        // a failed store leaves the identifier file as it was
        if (sw1 === CTI_SW1_OK) foreach (id_file[i]) id_file[i] = body[i];
      end else sw1 = 8'h6D;
      foreach (rsp[i]) send(rsp[i]);
      send(sw1);
      send(8'h00);
    end
  end
endmodule : cti_card_model

//--- tb/test_card_tag_and_identifier_commands.sv
`timescale 1ns/1ps
module test_card_tag_and_identifier_commands
  import cti_pkg::*;
;
  // store cases, two flag bits and one bit or byte per case
  localparam logic [15:0] S_FLAG = 16'h0ED0;
  localparam logic [7:0] S_ID = 8'h5C;
  localparam logic [7:0] S_USE = 8'hB1;
  localparam logic [7:0] S_FAIL = 8'h40;
  localparam logic [7:0] S_P1 = 8'h28;
  localparam logic [7:0] S_SHORT = 8'h20;
  localparam logic [63:0] S_RSP = 64'h1001_3110_0001_0011;
  logic clk_sys, rst, hwrite, hsel, hready, hresp, hreadyout, used;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic card_tx_valid, card_tx_ack, card_rx_valid, usage_ind, short_sel, fail_sw;
  logic [7:0] card_tx_byte, card_rx_byte, sel, n;
  logic [3:0] lag;
  logic [55:0] idv;
  logic [39:0] e;
  int err_total, checked;
  assign hready = hreadyout;

  cti_host i_dut (.clk_sys, .rst, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hsel, .hready, .hrdata, .hreadyout,
    .hresp, .card_tx_valid, .card_tx_byte, .card_tx_ack, .card_rx_valid, .card_rx_byte);
  cti_card_model i_card (.clk_sys, .card_tx_valid, .card_tx_byte, .card_tx_ack, .card_rx_valid, .card_rx_byte,
    .lag, .usage_ind, .short_sel, .fail_sw);

  // 125 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // -------------
  // shared tasks
  // -------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("mismatches %0d, comparisons %0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test

  // one word transfer; each phase held until hready is seen high
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    hsel <= 1'b1;
    @(posedge clk_sys);
    while (hready !== 1'b1) @(posedge clk_sys);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clk_sys);
    while (hready !== 1'b1) @(posedge clk_sys);
    rd = hrdata;
    check(hresp, 1'b0, "bus response");
  endtask : bus

  // start a command, poll until idle and done; rd ends as status
  task automatic run(input logic [31:0] ctrl);
    bus(1'b1, CTI_REG_CTRL, ctrl | 32'h8000_0000);
    rd = '0;
    for (int k = 0; k < 3000 && rd[8:7] !== 2'b11; k++) bus(1'b0, CTI_REG_STATUS, '0);
    check(rd[8:7], 2'b11, "command done");
  endtask : run

  // the five header bytes the card received
  task automatic hdr_is(input logic [7:0] ins, input logic [7:0] p1, input logic [7:0] p3);
    check(i_card.hdr[0], 8'hA0, "class");
    check(i_card.hdr[1], ins, "instruction");
    check(i_card.hdr[2], p1, "first parameter");
    check(i_card.hdr[3], 8'h00, "second parameter");
    check(i_card.hdr[4], p3, "body length");
  endtask : hdr_is

  // reply byte at an index; status bytes ride in the top half
  task automatic rsp_is(input int idx, input logic [7:0] exp);
    bus(1'b0, {20'h0_0000, idx[3:0], CTI_REG_RESP}, '0);
    check(rd[15:8], exp, "reply byte");
  endtask : rsp_is

  // -------------
  // main sequence
  // -------------
  initial begin
    rst = 1'b1;
    haddr = '0;
    htrans = '0;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = '0;
    hsel = 1'b0;
    lag = '0;
    usage_ind = 1'b0;
    short_sel = 1'b1;
    fail_sw = 1'b0;
    err_total = 0;
    checked = 0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    bus(1'b0, CTI_REG_STATUS, '0);
    check(rd[9:7], 3'b001, "status after reset");
    bus(1'b1, 32'h0000_0040, 32'hFFFF_FFFF);
    bus(1'b0, 32'h0000_0040, '0);
    check(rd, '0, "unmapped read");
    // store cases: both forms, change flag, usage, short form, a failed store
    for (int i = 0; i < 8; i++) begin
      idv = S_ID[i] ? 56'h13_5724_68AC_E0F1 : 56'h77_6655_4433_2211;
      usage_ind <= S_USE[i];
      fail_sw <= S_FAIL[i];
      lag <= 4'(i % 3);
      bus(1'b1, CTI_REG_ID_LO, idv[31:0]);
      bus(1'b1, CTI_REG_ID_HI, {8'h07, idv[55:32]});
      run({27'h000_0000, S_SHORT[i], S_FLAG[2*i +: 2], CTI_CMD_STORE});
      check(rd[9], S_FAIL[i], "error flag");
      hdr_is(8'hDE, {7'h00, S_P1[i]}, 8'h08);
      check(i_card.body[0], 8'h07, "length byte");
      for (int j = 1; j < 8; j++) check(i_card.body[j], idv[8*j-8 +: 8], "id byte");
      rsp_is(0, S_RSP[8*i +: 8]);
      check(rd[31:16], S_FAIL[i] ? 16'h6F00 : 16'h9000, "status words");
    end
    // configuration: selectors that do and do not take offset and size
    for (int i = 0; i < 5; i++) begin
      sel = i == 0 ? 8'h01 : (i == 4 ? 8'h07 : {4'h0, i[2:0], 1'b0});
      used = sel inside {8'h02, 8'h04, 8'h06};
      n = used ? 8'h04 : 8'h02;
      lag <= 4'(i % 2);
      bus(1'b1, CTI_REG_ARG, {8'h04, 8'h30, 8'h01, sel});
      run({16'h0000, n, 6'h00, CTI_CMD_TAG_CFG});
      hdr_is(8'hC8, 8'h00, 8'h04);
      // offset and size go out as zeros for selectors that do not use them
      check({i_card.body[0], i_card.body[1], i_card.body[2], i_card.body[3]},
        {sel, used ? 24'h01_3004 : 24'h00_0000}, "config body");
      rsp_is(0, sel);
      rsp_is(1, 8'h00);
      rsp_is(2, n);
      for (int j = 0; j < n; j++) rsp_is(3 + j, used ? 8'h30 + j[7:0] : 8'hEE);
      check(rd[31:16], 16'h9000, "status words");
    end
    // download: three parameter bytes, segment fields by selector
    for (int i = 0; i < 3; i++) begin
      sel = 8'h03 + i[7:0] - 8'h02 * i[0];
      used = sel inside {8'h01, 8'h02, 8'h03};
      lag <= 4'(2 * i);
      for (int k = 0; k < 3; k++) bus(1'b1, CTI_REG_DATA, {12'h000, k[3:0], 8'h00, 8'hC0 + k[7:0]});
      bus(1'b1, CTI_REG_ARG, {16'h0000, 8'h03, sel});
      run({16'h0000, 8'h03, 6'h00, CTI_CMD_TAG_DL});
      hdr_is(8'hCA, 8'h00, 8'h05);
      check({i_card.body[0], i_card.body[1], i_card.body[2], i_card.body[3]},
        {sel, 24'h03_C0C1}, "dl body");
      check(i_card.body[4], 8'hC2, "dl last byte");
      e = {sel, 8'h00, used ? 24'h00_0303 : 24'hFF_FFFF};
      for (int j = 0; j < 5; j++) rsp_is(j, e[39-8*j -: 8]);
      check(rd[31:16], 16'h9000, "status words");
    end
    stop_test();
  end

  // watchdog against a hung handshake
  initial begin
    repeat (60000) @(posedge clk_sys);
    err_total++;
    stop_test();
  end
endmodule : test_card_tag_and_identifier_commands
